// ==== rtl/level_monitor_virtual_links.sv ====
`timescale 1ns/1ps
`include "level_monitor_cfg.svh"

module level_monitor_virtual_links (
  input wire logic mclk, // system clock 100 MHz
  input wire logic rstn, // async reset, active low
  input wire logic [`NUM_QUANTITIES*`VALUE_WIDTH-1:0] quantity_bus, // values
  input wire logic [`NUM_ORIGINS-1:0] status_bus, // output-function statuses
  input wire logic [`NUM_FUNCS-1:0] physical_input_function, // pin funcs
  input wire logic [`NUM_LINKS*`FUNC_WIDTH-1:0] virtual_link_target, // tgt
  input wire logic [`NUM_LINKS*`ORIGIN_WIDTH-1:0] virtual_link_origin, // src
  input wire logic [`NUM_MONITORS*`QSEL_WIDTH-1:0] monitor_input_select, // q
  input wire logic [`NUM_MONITORS*`VALUE_WIDTH-1:0] upper_threshold, // set
  input wire logic [`NUM_MONITORS*`VALUE_WIDTH-1:0] lower_threshold, // rst
  input wire logic [`NUM_MONITORS-1:0] monitor_behaviour_select, // 1 window
  input wire logic [`NUM_MONITORS-1:0] signed_handling_select, // 1 signed
  input wire logic [`ORIGIN_WIDTH-1:0] physical_output_function, // out sel
  output logic [`NUM_FUNCS-1:0] function_active, // combined functions
  output logic [`NUM_MONITORS-1:0] monitor_out, // monitor outputs
  output logic [`NUM_LINKS-1:0] link_level, // virtual link levels
  output logic physical_output_level, // physical output drive
  output logic [`NUM_MONITORS-1:0] select_invalid // code above 26
);

  // ****************************************************************
  // origin set: statuses with monitor outputs spliced in
  // ****************************************************************
  logic [`NUM_ORIGINS-1:0] origin_bus;
  logic [`NUM_FUNCS-1:0] link_drive [`NUM_LINKS];
  logic [`NUM_FUNCS-1:0] link_or;
  logic phys_next;
  logic phys_reg;

  // monitors occupy the top origin codes so links and the physical output can pick them
  always_comb begin
    origin_bus = status_bus;
    for (int m = 0; m < `NUM_MONITORS; m++) begin
      origin_bus[int'(`ORIGIN_MON0) + m] = monitor_out[m];
    end
  end

  // ****************************************************************
  // threshold monitors
  // ****************************************************************
  genvar gm;
  generate
    for (gm = 0; gm < `NUM_MONITORS; gm++) begin : g_mon
      logic [`QSEL_WIDTH-1:0] qsel;
      logic signed [`VALUE_WIDTH-1:0] qval;
      wire sel_bad;
      assign qsel = monitor_input_select[gm*`QSEL_WIDTH +: `QSEL_WIDTH];
      // out of range code reads as zero rather than wrapping
      assign sel_bad = qsel > `QSEL_MAX;
      assign qval = sel_bad ? '0 :
        quantity_bus[qsel*`VALUE_WIDTH +: `VALUE_WIDTH];
      assign select_invalid[gm] = sel_bad;
      // range clamping of thresholds is the setter's job; the datapath
      // accepts the full signed span, covering minus the upper limit
      threshold_monitor u_mon (
        .mclk(mclk),
        .rstn(rstn),
        .value(qval),
        .upper_threshold(upper_threshold[gm*`VALUE_WIDTH +: `VALUE_WIDTH]),
        .lower_threshold(lower_threshold[gm*`VALUE_WIDTH +: `VALUE_WIDTH]),
        .behaviour(level_monitor_pkg::behaviour_t'(
          monitor_behaviour_select[gm])),
        .handling(level_monitor_pkg::handling_t'(
          signed_handling_select[gm])),
        .mon_out(monitor_out[gm])
      );
    end
  endgenerate

  // ****************************************************************
  // virtual links
  // ****************************************************************
  genvar gl;
  generate
    for (gl = 0; gl < `NUM_LINKS; gl++) begin : g_link
      virtual_link u_link (
        .mclk(mclk),
        .rstn(rstn),
        .origin_sel(virtual_link_origin[gl*`ORIGIN_WIDTH +: `ORIGIN_WIDTH]),
        .target_sel(virtual_link_target[gl*`FUNC_WIDTH +: `FUNC_WIDTH]),
        .origin_bus(origin_bus),
        .target_onehot(link_drive[gl]),
        .link_level(link_level[gl])
      );
    end
  endgenerate

  // ****************************************************************
  // function combination and physical output
  // ****************************************************************
  // several links on one function simply OR together as well
  always_comb begin
    link_or = '0;
    for (int l = 0; l < `NUM_LINKS; l++) begin
      link_or = link_or | link_drive[l];
    end
  end

  // slot zero is the off function and never goes active
  always_comb begin
    function_active = link_or | physical_input_function;
    function_active[0] = 1'b0;
  end

  assign phys_next = (physical_output_function == `ORIGIN_OFF) ? 1'b0 :
    origin_bus[physical_output_function];

  // physical output comes from a flop like the link levels
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      phys_reg <= 1'b0;
    end else begin
      phys_reg <= phys_next;
    end
  end
  assign physical_output_level = phys_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  // every pin-driven function other than off must show as active
  a_pin_or_link: assert property (@(posedge mclk) disable iff (!rstn)
    (physical_input_function[`NUM_FUNCS-1:1] &
    ~function_active[`NUM_FUNCS-1:1]) == '0)
    else $error("physical input did not reach function");
  a_link_reaches_func: assert property (@(posedge mclk) disable iff (!rstn)
    link_level[0] && virtual_link_target[`FUNC_WIDTH-1:0] == 7'h05
    |-> function_active[5])
    else $error("link did not reach its target function");
  a_monitor_as_origin: assert property (@(posedge mclk) disable iff (!rstn)
    virtual_link_origin[`ORIGIN_WIDTH-1:0] == `ORIGIN_MON0
    ##1 $stable(virtual_link_origin[`ORIGIN_WIDTH-1:0])
    |-> link_level[0] == $past(monitor_out[0]))
    else $error("link did not follow monitor");
  a_phys_follows: assert property (@(posedge mclk) disable iff (!rstn)
    physical_output_function == `ORIGIN_MON0
    |=> physical_output_level == $past(monitor_out[0]))
    else $error("physical output lagging");
  a_off_func_idle: assert property (@(posedge mclk) disable iff (!rstn)
    !function_active[0])
    else $error("off function driven");

  c_link_fires: cover property (@(posedge mclk) disable iff (!rstn)
    $rose(link_level[0]));
  c_both_sources: cover property (@(posedge mclk) disable iff (!rstn)
    |(link_or & physical_input_function));
  c_all_monitors: cover property (@(posedge mclk) disable iff (!rstn)
    &monitor_out);

endmodule : level_monitor_virtual_links

// ==== rtl/level_monitor_cfg.svh ====
`ifndef LEVEL_MONITOR_CFG_SVH
`define LEVEL_MONITOR_CFG_SVH

// ****************************************************************
// sizes
// ****************************************************************
`define VALUE_WIDTH 32
`define NUM_LINKS 8
`define NUM_MONITORS 4
`define NUM_QUANTITIES 27
`define QSEL_WIDTH 5
`define FUNC_WIDTH 7
`define NUM_FUNCS 128
`define ORIGIN_WIDTH 7
`define NUM_ORIGINS 128

// ****************************************************************
// selector codes: off and default values, upper limit, modes
// ****************************************************************
`define TARGET_OFF 7'h00
`define ORIGIN_OFF 7'h00
`define QSEL_DEFAULT 5'h01
`define QSEL_MAX 5'h1A
`define BEHAV_HYST 1'b0
`define BEHAV_WINDOW 1'b1
`define HANDLING_ABS 1'b0
`define HANDLING_SIGNED 1'b1

// ****************************************************************
// origin codes for the monitor outputs
// ****************************************************************
`define ORIGIN_MON0 7'h7C

`endif

// ==== rtl/level_monitor_pkg.sv ====
package level_monitor_pkg;

  // comparison behaviour of one monitor
  typedef enum logic {
    BEHAV_HYSTERESIS,
    BEHAV_WINDOW
  } behaviour_t;

  // input handling of one monitor
  typedef enum logic {
    HANDLE_ABSOLUTE,
    HANDLE_SIGNED
  } handling_t;

  // state of a hysteresis monitor
  typedef enum logic {
    MON_LOW,
    MON_HIGH
  } mon_state_t;

endpackage : level_monitor_pkg

// ==== rtl/virtual_link.sv ====
`timescale 1ns/1ps
`include "level_monitor_cfg.svh"

module virtual_link (
  input wire logic mclk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic [`ORIGIN_WIDTH-1:0] origin_sel, // origin code
  input wire logic [`FUNC_WIDTH-1:0] target_sel, // target function
  input wire logic [`NUM_ORIGINS-1:0] origin_bus, // internal status
  output logic [`NUM_FUNCS-1:0] target_onehot, // drive of functions
  output logic link_level // registered link level
);

  // ****************************************************************
  // origin pick and target decode
  // ****************************************************************
  logic link_next;
  logic target_live;
  wire origin_off = (origin_sel == `ORIGIN_OFF);
  wire target_off = (target_sel == `TARGET_OFF);

  // off origin is constant inactive
  assign link_next = origin_off ? 1'b0 : origin_bus[origin_sel];
  // off target drives no function at all
  assign target_live = link_level & ~target_off;

  always_comb begin
    target_onehot = '0;
    target_onehot[target_sel] = target_live;
  end

  // registered so a link loop settles one cycle per pass
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      link_level <= 1'b0;
    end else begin
      link_level <= link_next;
    end
  end

  a_off_origin_low: assert property (@(posedge mclk) disable iff (!rstn)
    $past(origin_off) |-> !link_level)
    else $error("link active with origin off");

endmodule : virtual_link

// ==== rtl/threshold_monitor.sv ====
`timescale 1ns/1ps
`include "level_monitor_cfg.svh"

module threshold_monitor (
  input wire logic mclk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic signed [`VALUE_WIDTH-1:0] value, // selected quantity
  input wire logic signed [`VALUE_WIDTH-1:0] upper_threshold, // set level
  input wire logic signed [`VALUE_WIDTH-1:0] lower_threshold, // reset lvl
  input wire level_monitor_pkg::behaviour_t behaviour, // hyst or window
  input wire level_monitor_pkg::handling_t handling, // abs or signed
  output logic mon_out // monitor output
);

  // ****************************************************************
  // value conditioning and comparison
  // ****************************************************************
  logic signed [`VALUE_WIDTH:0] cmp_val;
  logic signed [`VALUE_WIDTH:0] up_ext;
  logic signed [`VALUE_WIDTH:0] lo_ext;
  logic above_upper;
  logic below_lower;
  logic inside_band;
  logic mon_next;
  logic latch_mode;

  // one extra bit so the magnitude of the most negative value fits
  assign cmp_val = (handling == level_monitor_pkg::HANDLE_SIGNED) ?
    {value[`VALUE_WIDTH-1], value} :
    (value[`VALUE_WIDTH-1] ? -{value[`VALUE_WIDTH-1], value} :
    {1'b0, value});
  assign up_ext = {upper_threshold[`VALUE_WIDTH-1], upper_threshold};
  assign lo_ext = {lower_threshold[`VALUE_WIDTH-1], lower_threshold};
  // equality is not a crossing
  assign above_upper = cmp_val > up_ext;
  assign below_lower = cmp_val < lo_ext;
  // band is the span between the two levels, whichever is higher
  assign inside_band = (up_ext >= lo_ext) ?
    (cmp_val > lo_ext) && (cmp_val < up_ext) :
    (cmp_val > up_ext) && (cmp_val < lo_ext);

  // lower above upper: a plain reset would still fire below the upper
  // level, so the reset is cut off there and a set output stays latched
  assign latch_mode = lo_ext > up_ext;

  // set wins over reset; in latch mode only a reset of the block clears
  always_comb begin
    if (behaviour == level_monitor_pkg::BEHAV_WINDOW) begin
      mon_next = inside_band;
    end else if (above_upper) begin
      mon_next = 1'b1;
    end else if (below_lower && !latch_mode) begin
      mon_next = 1'b0;
    end else begin
      mon_next = mon_out;
    end
  end

  // evaluated every cycle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mon_out <= 1'b0;
    end else begin
      mon_out <= mon_next;
    end
  end

  a_hyst_set_high: assert property (@(posedge mclk) disable iff (!rstn)
    (behaviour == level_monitor_pkg::BEHAV_HYSTERESIS) && above_upper
    |=> mon_out)
    else $error("hysteresis not set above upper");
  a_hyst_reset_low: assert property (@(posedge mclk) disable iff (!rstn)
    (behaviour == level_monitor_pkg::BEHAV_HYSTERESIS) && below_lower
    && !above_upper && !latch_mode |=> !mon_out)
    else $error("hysteresis not reset below lower");
  a_latch_holds: assert property (@(posedge mclk) disable iff (!rstn)
    (behaviour == level_monitor_pkg::BEHAV_HYSTERESIS) && latch_mode
    && mon_out |=> mon_out)
    else $error("latched output dropped");
  a_hyst_hold_state: assert property (@(posedge mclk) disable iff (!rstn)
    (behaviour == level_monitor_pkg::BEHAV_HYSTERESIS) && !below_lower
    && !above_upper |=> $stable(mon_out))
    else $error("hysteresis changed between levels");
  a_window_follow: assert property (@(posedge mclk) disable iff (!rstn)
    (behaviour == level_monitor_pkg::BEHAV_WINDOW) |=>
    mon_out == $past(inside_band))
    else $error("window output not band membership");
  a_equal_no_set: assert property (@(posedge mclk) disable iff (!rstn)
    (behaviour == level_monitor_pkg::BEHAV_HYSTERESIS) && !mon_out
    && cmp_val == up_ext |=> !mon_out)
    else $error("set on equality");

  c_hyst_rise: cover property (@(posedge mclk) disable iff (!rstn)
    (behaviour == level_monitor_pkg::BEHAV_HYSTERESIS) && $rose(mon_out));
  c_window_in: cover property (@(posedge mclk) disable iff (!rstn)
    (behaviour == level_monitor_pkg::BEHAV_WINDOW) && $rose(mon_out));

endmodule : threshold_monitor

// ==== tb/quantity_source.sv ====
`timescale 1ns/1ps
`include "level_monitor_cfg.svh"

// ****************************************************************
// far side: internal value sources and status signals
// ****************************************************************
module quantity_source (
  input wire logic mclk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic wr_en, // load one quantity
  input wire logic [`QSEL_WIDTH-1:0] wr_sel, // quantity code
  input wire logic signed [`VALUE_WIDTH-1:0] wr_val, // new value
  input wire logic [`NUM_ORIGINS-1:0] status_in, // wanted statuses
  output logic [`NUM_QUANTITIES*`VALUE_WIDTH-1:0] quantity_bus, // values
  output logic [`NUM_ORIGINS-1:0] status_bus // status signals
);
  // values change only on a clock edge, as a sampled source would
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      quantity_bus <= '0;
      status_bus <= '0;
    end else begin
      status_bus <= status_in;
      if (wr_en) begin
        quantity_bus[wr_sel*`VALUE_WIDTH+:`VALUE_WIDTH] <= wr_val;
      end
    end
  end
endmodule : quantity_source

// ==== tb/level_monitor_virtual_links_tb.sv ====
`timescale 1ns/1ps
`include "level_monitor_cfg.svh"

module level_monitor_virtual_links_tb;
  typedef struct {
    int m;
    logic beh;
    logic hdl;
    logic signed [31:0] up;
    logic signed [31:0] lo;
    logic signed [31:0] val;
    logic want;
  } row_t;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic wr_en = 1'b0;
  logic [4:0] wr_sel = 5'h00;
  logic signed [31:0] wr_val = 32'h0;
  logic [127:0] status_in = '0;
  logic [`NUM_QUANTITIES*32-1:0] quantity_bus;
  logic [127:0] status_bus;
  logic [127:0] pins = '0;
  logic [55:0] tgt = '0;
  logic [55:0] org = '0;
  logic [19:0] qsel = {5'h04, 5'h03, 5'h02, 5'h01};
  logic [127:0] up_th = '0;
  logic [127:0] lo_th = '0;
  logic [3:0] beh = 4'h0;
  logic [3:0] hdl = 4'h0;
  logic [6:0] out_fn = 7'h00;
  logic [127:0] function_active;
  logic [3:0] monitor_out;
  logic [7:0] link_level;
  logic physical_output_level;
  logic [3:0] select_invalid;
  int err_count = 0;
  int check_count = 0;
  logic [127:0] exp_mon;
  logic [127:0] got_mon;
  // one monitor per block of rows; order matters for hysteresis history
  row_t rows [20] = '{
    '{0, 0, 0, 300, 200, 250, 0}, '{0, 0, 0, 300, 200, 300, 0},
    '{0, 0, 0, 300, 200, 301, 1}, '{0, 0, 0, 300, 200, 250, 1},
    '{0, 0, 0, 300, 200, 200, 1}, '{0, 0, 0, 300, 200, 199, 0},
    '{0, 0, 0, 300, 200, -400, 1}, '{0, 0, 0, 300, 200, 0, 0},
    '{1, 1, 1, 100, -100, 50, 1}, '{1, 1, 1, 100, -100, -50, 1},
    '{1, 1, 1, 100, -100, -150, 0}, '{1, 1, 1, 100, -100, 100, 0},
    '{1, 1, 1, 100, -100, 150, 0}, '{2, 1, 0, 100, 50, -75, 1},
    '{2, 1, 0, 100, 50, -120, 0}, '{3, 0, 1, 100, 200, 50, 0},
    '{3, 0, 1, 100, 200, 150, 1}, '{3, 0, 1, 100, 200, 50, 1},
    '{3, 0, 1, 100, 200, 250, 1}, '{3, 0, 1, 100, 200, 120, 1}
  };

  // ****************************************************************
  // clock, partner and design
  // ****************************************************************
  always #5 mclk = ~mclk;

  quantity_source src (.mclk(mclk), .rstn(rstn), .wr_en(wr_en),
    .wr_sel(wr_sel), .wr_val(wr_val), .status_in(status_in),
    .quantity_bus(quantity_bus), .status_bus(status_bus));

  level_monitor_virtual_links dut (.mclk(mclk), .rstn(rstn),
    .quantity_bus(quantity_bus), .status_bus(status_bus),
    .physical_input_function(pins), .virtual_link_target(tgt),
    .virtual_link_origin(org), .monitor_input_select(qsel),
    .upper_threshold(up_th), .lower_threshold(lo_th),
    .monitor_behaviour_select(beh), .signed_handling_select(hdl),
    .physical_output_function(out_fn), .function_active(function_active),
    .monitor_out(monitor_out), .link_level(link_level),
    .physical_output_level(physical_output_level),
    .select_invalid(select_invalid));

  // ****************************************************************
  // compare and closing tasks
  // ****************************************************************
  task automatic check_vec(input string what, input logic [127:0] want,
                           input logic [127:0] got);
    check_count++;
    if (got !== want) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, got);
    end
  endtask : check_vec

  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  // three edges cover partner register plus design register
  task automatic settle();
    repeat (3) @(posedge mclk);
    @(negedge mclk);
  endtask : settle

  task automatic put_value(input int m, input logic signed [31:0] v);
    @(posedge mclk);
    wr_en <= 1'b1;
    wr_sel <= 5'(m + 1);
    wr_val <= v;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask : put_value

  // watchdog sized well above the roughly 180 cycles of the run
  initial begin
    #200000;
    err_count++;
    end_of_test();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    check_vec("monitor_out", '0, 128'(monitor_out));
    // released on the third rising edge, like every other input
    @(posedge mclk);
    rstn <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge mclk);
      beh[rows[i].m] <= rows[i].beh;
      hdl[rows[i].m] <= rows[i].hdl;
      up_th[rows[i].m*32+:32] <= rows[i].up;
      lo_th[rows[i].m*32+:32] <= rows[i].lo;
      put_value(rows[i].m, rows[i].val);
      settle();
      exp_mon = 128'(rows[i].want);
      got_mon = 128'(monitor_out[rows[i].m]);
      check_vec("mon", exp_mon, got_mon);
    end
    // selector boundary: 26 is valid, 27 is refused
    @(posedge mclk);
    qsel[19:15] <= 5'h1B;
    settle();
    check_vec("select_invalid", 128'h8, 128'(select_invalid));
    @(posedge mclk);
    qsel[19:15] <= 5'h1A;
    settle();
    check_vec("select_invalid", '0, 128'(select_invalid));
    // each link routes its own status to its own function
    for (int n = 0; n < 8; n++) begin
      @(posedge mclk);
      tgt[n*7+:7] <= 7'(n + 20);
      org[n*7+:7] <= 7'(n + 10);
      status_in <= 128'h1 << (n + 10);
      settle();
      check_vec("link_level", 128'h1 << n, 128'(link_level));
      check_vec("function_active", 128'h1 << (n + 20), function_active);
    end
    @(posedge mclk);
    status_in <= 128'h1 | (128'h1 << 10);
    pins <= 128'h1 << 27;
    tgt[6:0] <= `TARGET_OFF;
    org[13:7] <= `ORIGIN_OFF;
    settle();
    check_vec("link_level", 128'h1, 128'(link_level));
    check_vec("function_active", 128'h1 << 27, function_active);
    // monitor 0 feeds a link and the physical output
    @(posedge mclk);
    // statuses cleared so link 0 can only be high through the monitor
    status_in <= '0;
    org[6:0] <= `ORIGIN_MON0;
    tgt[6:0] <= 7'h05;
    out_fn <= `ORIGIN_MON0;
    put_value(0, 500);
    settle();
    check_vec("link_level", 128'h1, 128'(link_level));
    check_vec("fa", (128'h1 << 27) | 128'h20, function_active);
    check_vec("physical_out", 128'h1, 128'(physical_output_level));
    // second reset in mid-run clears all registered outputs
    @(posedge mclk);
    rstn <= 1'b0;
    @(negedge mclk);
    check_vec("monitor_out", '0, 128'(monitor_out));
    check_vec("link_level", '0, 128'(link_level));
    check_vec("physical_out", '0, 128'(physical_output_level));
    check_vec("function_active", pins, function_active);
    @(posedge mclk);
    rstn <= 1'b1;
    settle();
    // partner values are zero again: only the signed window of monitor 1
    // holds zero inside its band, the latch of monitor 3 stays cleared
    check_vec("monitor_out", 128'h2, 128'(monitor_out));
    end_of_test();
  end
endmodule : level_monitor_virtual_links_tb
